//--- shared/anp_pkg.sv
// Constants for the next-page register bank: register indices, field
// positions and reset values.
// Assumes a 32-bit Wishbone slave with one aligned word per register index.
package anp_pkg;

    localparam int unsigned ANP_DW        = 16;
    localparam int unsigned IDX_W         = 5;
    localparam int unsigned WB_IDX_LSB    = 2;

    // Register indices; byte address is four times the index
    localparam logic [4:0]  IDX_EXP       = 5'h06;
    localparam logic [4:0]  IDX_TX        = 5'h07;
    localparam logic [4:0]  IDX_RX        = 5'h08;
    localparam logic [4:0]  IDX_PCFG      = 5'h10;
    localparam logic [4:0]  IDX_STS2      = 5'h11;
    localparam logic [4:0]  IDX_SCHG      = 5'h13;
    localparam logic [4:0]  IDX_LED       = 5'h14;
    localparam logic [4:0]  IDX_DCFG      = 5'h1a;
    localparam logic [4:0]  IDX_TXC       = 5'h1e;

    // Code word fields
    localparam int unsigned MORE_BIT      = 15;
    localparam int unsigned RSVD_BIT      = 14;
    localparam int unsigned RX_ACK_BIT    = 14;
    localparam int unsigned MSG_BIT       = 13;
    localparam int unsigned COMPLY_BIT    = 12;
    localparam int unsigned TOGGLE_BIT    = 11;
    localparam int unsigned CODE_MSB      = 10;
    localparam int unsigned PAGE_RCVD_BIT = 1;

    localparam logic [15:0] TX_RESET      = 16'h2001;
    localparam logic [15:0] TX_WMASK      = 16'hbfff;
    localparam logic [15:0] RX_RESET      = 16'h0000;
    localparam logic [15:0] CFG_RESET     = 16'h0000;
    localparam logic [15:0] ZERO16        = 16'h0000;

endpackage : anp_pkg

//--- shared/anp_rx_if.sv
// Carrier between the register bank and its received-page capture unit.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
interface anp_rx_if;
    logic        page_valid;
    logic [15:0] page_word;
    logic        rd_clear;
    logic [15:0] rx_word;
    logic        page_rcvd;

    modport cap  (input page_valid, page_word, rd_clear, output rx_word, page_rcvd);
    modport regs (output page_valid, page_word, rd_clear, input rx_word, page_rcvd);
endinterface : anp_rx_if

//--- logic/anp_rx_capture.sv
// Holds the partner's latest next-page word and the latching page flag.
// Assumes page_valid is a one-cycle pulse from the negotiation logic.
`timescale 1ns/1ps
module anp_rx_capture (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic resetn_i,
    // Register side
    anp_rx_if.cap     rx
);
    import anp_pkg::*;

    logic [15:0] word_q;
    logic [15:0] word_d;
    logic        flag_q;
    logic        flag_d;

    always_comb begin
        word_d = word_q;
        flag_d = flag_q;
        if (rx.page_valid) begin
            word_d = rx.page_word;
        end
        // New page beats a read clear in the same cycle
        if (rx.page_valid) begin
            flag_d = 1'b1;
        end else if (rx.rd_clear) begin
            flag_d = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            word_q <= RX_RESET;
            flag_q <= 1'b0;
        end else begin
            word_q <= word_d;
            flag_q <= flag_d;
        end
    end

    assign rx.rx_word   = word_q;
    assign rx.page_rcvd = flag_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    a_rx_word_load: assert property (
        rx.page_valid |=> rx.rx_word == $past(rx.page_word))
        else $error("received word not loaded");

    a_page_flag_set: assert property (
        rx.page_valid |=> rx.page_rcvd ##1 (rx.page_rcvd || $past(rx.rd_clear)))
        else $error("page flag not set or lost");

    a_page_flag_clr: assert property (
        (rx.rd_clear && !rx.page_valid) |=> !rx.page_rcvd)
        else $error("page flag not cleared on read");

    a_rx_word_hold: assert property (
        !rx.page_valid |=> $stable(rx.rx_word))
        else $error("received word changed without a page");

endmodule : anp_rx_capture

//--- logic/anp_regs.sv
// Next-page register bank with Wishbone classic slave access.
// Assumes rx_page_valid_i is a one-cycle pulse with the partner's word,
// and the product-specific status words come from elsewhere in the device.
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ps

// Functional notes
// - The transmit next-page word lives at register index 7.
// - Transmit bit 15 is writable, resets to 0, and says more pages follow.
// - Transmit bit 13 is writable, resets to 1, and marks a message page.
// - Transmit bit 12 is writable, resets to 0, and says we can comply.
// - Transmit bit 11 is the writable toggle, reset 0, inverse of the last one sent.
// - Transmit bits 10..0 are writable with reset one; bit 14 reads zero.
// - The received next-page word lives at index 8, read-only, reset zero.
// - Received bit 15 shows that the partner has more pages.
// - Received bit 14 shows that the partner got our code word.
// - Received bit 13 shows the partner's message page flag.
// - Received bit 12 shows that the partner can comply.
// - Received bit 11 shows the partner's toggle.
// - Indices 16, 17, 19, 20, 26 and 30 decode; 18, 21-25, 27-29, 31 are reserved.
// - A new page loads the received word and sets a flag that clears on read.
module anp_regs #(
    parameter int unsigned AW = 8
) (
    // Clock and reset
    input  wire logic                         clk_i,
    input  wire logic                         resetn_i,
    // Wishbone classic slave
    input  wire logic                         wb_cyc_i,
    input  wire logic                         wb_stb_i,
    input  wire logic                         wb_we_i,
    input  wire logic [AW-1:0]                wb_adr_i,
    input  wire logic [3:0]                   wb_sel_i,
    input  wire logic [31:0]                  wb_dat_i,
    output logic      [31:0]                  wb_dat_o,
    output logic                              wb_ack_o,
    // Negotiation link side
    input  wire logic                         rx_page_valid_i,
    input  wire logic [anp_pkg::ANP_DW-1:0]   rx_page_word_i,
    output logic      [anp_pkg::ANP_DW-1:0]   tx_page_word_o,
    // Product-specific status words
    input  wire logic [anp_pkg::ANP_DW-1:0]   status2_i,
    input  wire logic [anp_pkg::ANP_DW-1:0]   status_chg_i,
    // Product-specific configuration words
    output logic      [anp_pkg::ANP_DW-1:0]   port_cfg_o,
    output logic      [anp_pkg::ANP_DW-1:0]   led_cfg_o,
    output logic      [anp_pkg::ANP_DW-1:0]   dig_cfg_o,
    output logic      [anp_pkg::ANP_DW-1:0]   tx_ctrl_o
);
    import anp_pkg::*;

    localparam int unsigned NCFG   = 4;
    localparam int unsigned IDX_HI = WB_IDX_LSB + IDX_W;
    localparam int unsigned BYTE_W = 8;

    // Configuration slots for the writable product-specific words
    function automatic logic [2:0] cfg_slot(input logic [4:0] i);
        case (i)
            IDX_PCFG: cfg_slot = 3'h4;
            IDX_LED:  cfg_slot = 3'h5;
            IDX_DCFG: cfg_slot = 3'h6;
            IDX_TXC:  cfg_slot = 3'h7;
            default:  cfg_slot = 3'h0;
        endcase
    endfunction : cfg_slot

    anp_rx_if rx_bus ();

    logic        ack_q;
    logic        ack_d;
    logic [31:0] dat_q;
    logic [31:0] dat_d;
    logic [15:0] tx_q;
    logic [15:0] tx_d;
    logic [15:0] cfg_q [NCFG];
    logic [15:0] cfg_d [NCFG];

    logic        req;
    logic        adr_ok;
    logic [4:0]  idx;
    logic        wr;
    logic        rd;
    logic [15:0] wdat;
    logic [15:0] bmask;
    logic [15:0] tmask;
    logic [15:0] rdata;
    logic [2:0]  slot;

    // A new request is taken only while no answer is pending
    assign req    = wb_cyc_i & wb_stb_i & ~ack_q;
    assign idx    = wb_adr_i[IDX_HI-1:WB_IDX_LSB];
    // Addresses beyond the 32-word space answer but touch nothing
    assign adr_ok = (wb_adr_i >> IDX_HI) == '0;
    assign wr     = req & wb_we_i & adr_ok;
    assign rd     = req & ~wb_we_i & adr_ok;
    assign wdat   = wb_dat_i[15:0];
    assign bmask  = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign tmask  = bmask & TX_WMASK;
    assign slot   = cfg_slot(idx);

    // Received-page capture
    assign rx_bus.page_valid = rx_page_valid_i;
    assign rx_bus.page_word  = rx_page_word_i;
    // The flag is handed back with the data, then cleared
    assign rx_bus.rd_clear   = rd && (idx == IDX_EXP);

    anp_rx_capture u_rx_capture (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .rx       (rx_bus.cap)
    );

    // Read multiplexer; reserved and unmapped words read as zero
    always_comb begin
        rdata = ZERO16;
        case (idx)
            IDX_EXP: begin
                rdata[PAGE_RCVD_BIT] = rx_bus.page_rcvd;
            end
            IDX_TX: begin
                rdata = tx_q;
            end
            IDX_RX: begin
                rdata = rx_bus.rx_word;
            end
            IDX_STS2: begin
                rdata = status2_i;
            end
            IDX_SCHG: begin
                rdata = status_chg_i;
            end
            IDX_PCFG, IDX_LED, IDX_DCFG, IDX_TXC: begin
                rdata = cfg_q[slot[1:0]];
            end
            default: begin
                rdata = ZERO16;
            end
        endcase
        if (!adr_ok) begin
            rdata = ZERO16;
        end
    end

    // Next-state for bus answer and writable registers
    always_comb begin
        ack_d = req;
        dat_d = '0;
        tx_d  = tx_q;
        for (int k = 0; k < NCFG; k++) begin
            cfg_d[k] = cfg_q[k];
        end
        if (rd) begin
            dat_d = {ZERO16, rdata};
        end
        if (wr && (idx == IDX_TX)) begin
            // Bit 14 is outside the mask and stays zero
            tx_d = (tx_q & ~tmask) | (wdat & tmask);
        end
        if (wr && slot[2]) begin
            cfg_d[slot[1:0]] = (cfg_q[slot[1:0]] & ~bmask) | (wdat & bmask);
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ack_q <= 1'b0;
            dat_q <= '0;
            tx_q  <= TX_RESET;
            for (int k = 0; k < NCFG; k++) begin
                cfg_q[k] <= CFG_RESET;
            end
        end else begin
            ack_q <= ack_d;
            dat_q <= dat_d;
            tx_q  <= tx_d;
            for (int k = 0; k < NCFG; k++) begin
                cfg_q[k] <= cfg_d[k];
            end
        end
    end

    assign wb_ack_o       = ack_q;
    assign wb_dat_o       = dat_q;
    assign tx_page_word_o = tx_q;
    assign port_cfg_o     = cfg_q[0];
    assign led_cfg_o      = cfg_q[1];
    assign dig_cfg_o      = cfg_q[2];
    assign tx_ctrl_o      = cfg_q[3];

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence

    sequence s_wr_tx_full;
        s_req ##0 (wb_we_i && adr_ok && idx == IDX_TX && wb_sel_i[1:0] == 2'h3);
    endsequence

    sequence s_wr_rx;
        s_req ##0 (wb_we_i && adr_ok && idx == IDX_RX);
    endsequence

    sequence s_rd_rx;
        s_req ##0 (!wb_we_i && adr_ok && idx == IDX_RX && !rx_page_valid_i);
    endsequence

    sequence s_rd_resv;
        s_req ##0 (!wb_we_i && adr_ok && cfg_slot(idx) == 3'h0 && idx != IDX_EXP
                   && idx != IDX_TX && idx != IDX_RX && idx != IDX_STS2
                   && idx != IDX_SCHG);
    endsequence

    sequence s_wr_full(logic [4:0] i);
        s_req ##0 (wb_we_i && adr_ok && idx == i && wb_sel_i[1:0] == 2'h3);
    endsequence

    sequence s_wr_tx_lane(logic [1:0] lanes);
        s_req ##0 (wb_we_i && adr_ok && idx == IDX_TX && wb_sel_i[1:0] == lanes);
    endsequence

    sequence s_rd_idx(logic [4:0] i);
        s_req ##0 (!wb_we_i && adr_ok && idx == i);
    endsequence

    a_ack_one_cycle: assert property (
        s_req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single cycle after request");

    a_tx_rsvd_zero: assert property (
        tx_page_word_o[RSVD_BIT] == 1'b0)
        else $error("reserved transmit bit not zero");

    a_tx_write_full: assert property (
        s_wr_tx_full |=> tx_page_word_o[MORE_BIT] == $past(wb_dat_i[MORE_BIT])
                     && tx_page_word_o[MSG_BIT:0] == $past(wb_dat_i[MSG_BIT:0]))
        else $error("transmit word not written");

    a_tx_stable_idle: assert property (
        !(wr && idx == IDX_TX) |=> $stable(tx_page_word_o))
        else $error("transmit word changed without a write");

    a_rx_write_ignored: assert property (
        (s_wr_rx ##0 !rx_page_valid_i) |=> $stable(rx_bus.rx_word))
        else $error("write changed received word");

    a_rx_read_data: assert property (
        s_rd_rx |=> wb_dat_o == {ZERO16, $past(rx_bus.rx_word)})
        else $error("received word read back wrong");

    a_resv_read_zero: assert property (
        s_rd_resv |=> wb_dat_o == '0)
        else $error("reserved index not zero");

    a_flag_read_clear: assert property (
        (s_req ##0 (!wb_we_i && adr_ok && idx == IDX_EXP && !rx_page_valid_i))
        |=> wb_dat_o[PAGE_RCVD_BIT] == $past(rx_bus.page_rcvd) && !rx_bus.page_rcvd)
        else $error("page flag read or clear wrong");

    a_tx_read_data: assert property (
        s_rd_idx(IDX_TX) |=> wb_dat_o == {ZERO16, $past(tx_page_word_o)})
        else $error("transmit word read back wrong");

    a_tx_low_lane: assert property (
        s_wr_tx_lane(2'h1) |=> tx_page_word_o[BYTE_W-1:0] == $past(wdat[BYTE_W-1:0])
                            && $stable(tx_page_word_o[ANP_DW-1:BYTE_W]))
        else $error("low byte lane write wrong");

    // Reserved bit must drop out even when its lane is enabled
    a_tx_high_lane: assert property (
        s_wr_tx_lane(2'h2) |=> $stable(tx_page_word_o[BYTE_W-1:0])
                            && tx_page_word_o[ANP_DW-1:BYTE_W]
                               == ($past(wdat[ANP_DW-1:BYTE_W]) & TX_WMASK[ANP_DW-1:BYTE_W]))
        else $error("high byte lane write wrong");

    a_port_cfg_write: assert property (
        s_wr_full(IDX_PCFG) |=> port_cfg_o == $past(wdat))
        else $error("port configuration word not written");

    a_led_cfg_write: assert property (
        s_wr_full(IDX_LED) |=> led_cfg_o == $past(wdat))
        else $error("LED configuration word not written");

    a_dig_cfg_write: assert property (
        s_wr_full(IDX_DCFG) |=> dig_cfg_o == $past(wdat))
        else $error("digital configuration word not written");

    a_txc_cfg_write: assert property (
        s_wr_full(IDX_TXC) |=> tx_ctrl_o == $past(wdat))
        else $error("transmit control word not written");

    a_cfg_stable_idle: assert property (
        !(wr && slot[2]) |=> $stable(port_cfg_o) && $stable(led_cfg_o)
                          && $stable(dig_cfg_o) && $stable(tx_ctrl_o))
        else $error("configuration word changed without a write");

    a_sts2_read_data: assert property (
        s_rd_idx(IDX_STS2) |=> wb_dat_o == {ZERO16, $past(status2_i)})
        else $error("second status word read back wrong");

    a_schg_read_data: assert property (
        s_rd_idx(IDX_SCHG) |=> wb_dat_o == {ZERO16, $past(status_chg_i)})
        else $error("status change word read back wrong");

    a_unmapped_read_zero: assert property (
        (s_req ##0 (!wb_we_i && !adr_ok)) |=> wb_dat_o == '0)
        else $error("unmapped address not zero");

    // Read data must not linger once the answer is gone
    a_dat_idle_zero: assert property (
        !wb_ack_o |-> wb_dat_o == '0)
        else $error("read data driven without ack");

    a_ack_needs_req: assert property (
        wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i) && !$past(wb_ack_o))
        else $error("ack without a taken request");

endmodule : anp_regs

//--- bench/anp_partner_model.sv
// Behavioural link partner: hands next-page code words to the bank.
// Assumes the bank samples the word at the edge where valid is high.
`timescale 1ns/1ps
module anp_partner_model (
    // Clock
    input  wire logic        clk_i,
    // Page strobe and word
    output logic             page_valid_o,
    output logic [15:0]      page_word_o
);
    initial begin
        page_valid_o = 1'b0;
        page_word_o  = 16'h0000;
    end

    // Word turns to its inverse once released, so a late capture shows up
    task automatic send(input logic [15:0] word);
        @(posedge clk_i);
        page_valid_o <= 1'b1;
        page_word_o  <= word;
        @(posedge clk_i);
        page_valid_o <= 1'b0;
        page_word_o  <= ~word;
    endtask : send
endmodule : anp_partner_model

//--- bench/anp_regs_test.sv
// Self-checking bench for the next-page register bank.
// Assumes one 125 MHz clock and a Wishbone master that waits for each ack.
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin mismatches++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module anp_regs_test;
    import anp_pkg::*;
    logic        clk_i, resetn_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, rx_page_valid_i;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [15:0] rx_page_word_i, tx_page_word_o, status2_i, status_chg_i, rd_q;
    logic [15:0] port_cfg_o, led_cfg_o, dig_cfg_o, tx_ctrl_o;
    int          mismatches = 0;
    int          total_checks = 0;

    anp_regs #(.AW(8)) dut (
        .clk_i(clk_i), .resetn_i(resetn_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_page_valid_i(rx_page_valid_i),
        .rx_page_word_i(rx_page_word_i), .tx_page_word_o(tx_page_word_o),
        .status2_i(status2_i), .status_chg_i(status_chg_i), .port_cfg_o(port_cfg_o),
        .led_cfg_o(led_cfg_o), .dig_cfg_o(dig_cfg_o), .tx_ctrl_o(tx_ctrl_o));

    anp_partner_model dut_partner (
        .clk_i(clk_i), .page_valid_o(rx_page_valid_i), .page_word_o(rx_page_word_i));

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    task automatic final_report;
        if (mismatches == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : final_report

    // Upper data half carries junk on purpose; the bank must ignore it
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                        input logic [15:0] d);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= {16'hdead, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 16);
        if (wb_ack_o !== 1'b1) begin
            mismatches++;
            final_report();
        end
        rd_q = wb_dat_o[15:0];
        `CHK(wb_dat_o[31:16], 16'h0000)
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : xfer

    task automatic wr(input logic [4:0] idx, input logic [3:0] sel, input logic [15:0] d);
        xfer(1'b1, {1'b0, idx, 2'b00}, sel, d);
    endtask : wr

    task automatic rd(input logic [4:0] idx);
        xfer(1'b0, {1'b0, idx, 2'b00}, 4'hf, 16'h0000);
    endtask : rd

    task automatic do_reset;
        resetn_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        resetn_i <= 1'b1;
    endtask : do_reset

    task automatic t_reset_values;
        rd(IDX_TX);
        `CHK(rd_q, 16'h2001)
        `CHK(tx_page_word_o, 16'h2001)
        rd(IDX_RX);
        `CHK(rd_q, 16'h0000)
        rd(IDX_EXP);
        `CHK(rd_q, 16'h0000)
    endtask : t_reset_values

    // Walks each flag through both values using byte lanes
    task automatic t_tx_fields;
        wr(IDX_TX, 4'h3, 16'hffff);
        rd(IDX_TX);
        `CHK(rd_q, 16'hbfff)
        `CHK(tx_page_word_o, 16'hbfff)
        wr(IDX_TX, 4'h1, 16'h0000);
        rd(IDX_TX);
        `CHK(rd_q, 16'hbf00)
        wr(IDX_TX, 4'h2, 16'h4000);
        rd(IDX_TX);
        `CHK(rd_q, 16'h0000)
    endtask : t_tx_fields

    task automatic t_rx_page;
        dut_partner.send(16'h5aaa);
        rd(IDX_RX);
        `CHK(rd_q, 16'h5aaa)
        rd(IDX_EXP);
        `CHK(rd_q, 16'h0002)
        rd(IDX_EXP);
        `CHK(rd_q, 16'h0000)
        dut_partner.send(16'h0123);
        dut_partner.send(16'ha555);
        wr(IDX_RX, 4'h3, 16'hffff);
        rd(IDX_RX);
        `CHK(rd_q, 16'ha555)
    endtask : t_rx_page

    // Page lands on the very edge that takes the clearing read: set must win
    task automatic t_flag_race;
        rd(IDX_EXP);
        `CHK(rd_q, 16'h0002)
        fork
            dut_partner.send(16'h0f0f);
            begin
                @(posedge clk_i);
                rd(IDX_EXP);
            end
        join
        `CHK(rd_q, 16'h0000)
        rd(IDX_EXP);
        `CHK(rd_q, 16'h0002)
        rd(IDX_RX);
        `CHK(rd_q, 16'h0f0f)
    endtask : t_flag_race

    task automatic t_product_map;
        logic [4:0] cfg [4] = '{IDX_PCFG, IDX_LED, IDX_DCFG, IDX_TXC};
        logic [4:0] rsv [5] = '{5'h12, 5'h15, 5'h19, 5'h1d, 5'h1f};
        for (int k = 0; k < 4; k++) wr(cfg[k], 4'h3, 16'h0c30 + 16'(k));
        `CHK(({port_cfg_o, led_cfg_o, dig_cfg_o, tx_ctrl_o}), 64'h0c30_0c31_0c32_0c33)
        for (int k = 0; k < 4; k++) begin
            rd(cfg[k]);
            `CHK(rd_q, 16'h0c30 + 16'(k))
        end
        status2_i    <= 16'h96e1;
        status_chg_i <= 16'h1e69;
        rd(IDX_STS2);
        `CHK(rd_q, 16'h96e1)
        rd(IDX_SCHG);
        `CHK(rd_q, 16'h1e69)
        for (int k = 0; k < 5; k++) begin
            wr(rsv[k], 4'h3, 16'hffff);
            rd(rsv[k]);
            `CHK(rd_q, 16'h0000)
        end
        // Index 7 aliased above the map must not reach the transmit word
        xfer(1'b1, 8'h9c, 4'h3, 16'h1234);
        `CHK(tx_page_word_o, 16'h0000)
        xfer(1'b0, 8'h9c, 4'hf, 16'h0000);
        `CHK(rd_q, 16'h0000)
    endtask : t_product_map

    task automatic t_second_reset;
        wr(IDX_TX, 4'h3, 16'h1234);
        do_reset();
        rd(IDX_TX);
        `CHK(rd_q, 16'h2001)
        rd(IDX_RX);
        `CHK(rd_q, 16'h0000)
    endtask : t_second_reset

    initial begin
        resetn_i     = 1'b0;
        wb_cyc_i     = 1'b0;
        wb_stb_i     = 1'b0;
        wb_we_i      = 1'b0;
        wb_adr_i     = 8'h00;
        wb_sel_i     = 4'h0;
        wb_dat_i     = 32'h0000_0000;
        status2_i    = 16'h0000;
        status_chg_i = 16'h0000;
        do_reset();
        t_reset_values();
        t_tx_fields();
        t_rx_page();
        t_flag_race();
        t_product_map();
        t_second_reset();
        final_report();
    end
endmodule : anp_regs_test
